// ===== host_wake_model.sv
`timescale 1ns/100ps
module host_wake_model
(
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic rst_n,
   // Wake line and acknowledge
   input  wire logic wake_event_out_n,
   input  wire logic seen_clr,
   output logic      wake_seen
);
   // Host latches a wake until software acknowledges, so short pulses are not lost
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         wake_seen <= 1'b0;
      else
         wake_seen <= !wake_event_out_n || (wake_seen && !seen_clr);
   end
endmodule // host_wake_model

// ===== test_wake_smi_regs.sv
`timescale 1ns/100ps
module test_wake_smi_regs
   import wake_smi_pkg::*;
();
   logic        core_clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic        grouped_smi_in = 1'b0, printer_acknowledge_in = 1'b1, seen_clr = 1'b0;
   logic        hreadyout, hresp, wake_event_out_n, irq, wake_seen;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  orst = 3'h0;
   logic [3:0]  src = 4'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, pins = 32'h0, hrdata, rd;
   int          n_mismatch = 0, n_compared = 0, cyc = 0;

   wake_smi_regs wake_smi_regs_i (
      .*, .main_power_reset(orst[0]), .soft_reset(orst[1]), .hard_reset(orst[2]),
      .hsize(3'h2), .hready(hreadyout), .wake_pins_b(pins[7:0]), .wake_pins_c(pins[15:8]),
      .wake_pins_d(pins[23:16]), .wake_pins_e(pins[31:24]), .serial_two_irq(src[0]),
      .serial_one_irq(src[1]), .floppy_irq(src[2]), .midi_unit_irq(src[3]));
   host_wake_model host_wake_model_i (.*);

   always #2.5 core_clk = ~core_clk;
   // Hang guard
   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         n_mismatch++;
         summarize();
      end
   end

   task automatic summarize();
      if (n_mismatch == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic bus(input logic w, input logic [5:0] i, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= {24'h0, i, 2'h0};
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge core_clk);
      while (hreadyout !== 1'b1) @(posedge core_clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge core_clk);
      while (hreadyout !== 1'b1) @(posedge core_clk);
      rd = hrdata;
   endtask

   task automatic rdchk(input logic [5:0] i, input logic [31:0] exp);
      bus(1'b0, i, 32'h0);
      check($sformatf("reg %h", i), exp, rd);
   endtask

   task automatic pulse(input int k);
      orst <= 3'h1 << k;
      @(posedge core_clk);
      orst <= 3'h0;
      @(posedge core_clk);
   endtask

   task automatic t_reset_values();
      for (int i = 0; i < 4; i++)
         rdchk(6'(IDX_WAKE_EN_B + i), 32'h0);
      rdchk(IDX_RSVD_ZERO, 32'h0);
      rdchk(IDX_SMI_STS, 32'h2);
      rdchk(6'h3f, 32'h0);
   endtask

   task automatic t_enables_rw();
      for (int i = 0; i < 4; i++)
         bus(1'b1, 6'(IDX_WAKE_EN_B + i), 32'hffff_ff00 | (32'h5a ^ i));
      bus(1'b1, IDX_RSVD_ZERO, 32'hff);
      for (int k = 0; k < 3; k++)
         pulse(k);
      for (int i = 0; i < 4; i++)
         rdchk(6'(IDX_WAKE_EN_B + i), 32'h5a ^ i);
      rdchk(IDX_RSVD_ZERO, 32'h0);
      for (int i = 0; i < 4; i++)
         bus(1'b1, 6'(IDX_WAKE_EN_B + i), 32'h0);
   endtask

   task automatic t_smi_status();
      for (int b = 0; b < 4; b++)
      begin
         src <= 4'h1 << b;
         repeat (3) @(posedge core_clk);
         rdchk(IDX_SMI_STS, 32'h2 | (32'h4 << b));
         bus(1'b1, IDX_SMI_STS, 32'hff);
         rdchk(IDX_SMI_STS, 32'h2 | (32'h4 << b));
         src <= 4'h0;
         repeat (3) @(posedge core_clk);
         rdchk(IDX_SMI_STS, 32'h2);
      end
      bus(1'b1, IDX_CONTROL, 32'h2);
      printer_acknowledge_in <= 1'b0;
      repeat (5) @(posedge core_clk);
      rdchk(IDX_SMI_STS, 32'h0);
      printer_acknowledge_in <= 1'b1;
      repeat (5) @(posedge core_clk);
      rdchk(IDX_SMI_STS, 32'h2);
      printer_acknowledge_in <= 1'b0;
      repeat (5) @(posedge core_clk);
      pulse(1);
      rdchk(IDX_SMI_STS, 32'h2);
   endtask

   task automatic t_wake();
      bus(1'b1, IDX_WAKE_EN_B, 32'h1);
      bus(1'b1, IDX_CONTROL, 32'h1);
      pins <= 32'h8040_0002;
      repeat (5) @(posedge core_clk);
      check("wake_out", 32'h1, wake_event_out_n);
      rdchk(IDX_WAKE_STS_B, 32'h2);
      rdchk(IDX_WAKE_STS_D, 32'h40);
      rdchk(IDX_WAKE_STS_E, 32'h80);
      pins <= 32'h1;
      repeat (6) @(posedge core_clk);
      check("wake_out", 32'h0, wake_event_out_n);
      check("host_seen", 32'h1, wake_seen);
      pins <= 32'h0;
      repeat (4) @(posedge core_clk);
      bus(1'b1, IDX_WAKE_STS_B, 32'h0);
      rdchk(IDX_WAKE_STS_B, 32'h3);
      bus(1'b1, IDX_WAKE_STS_B, 32'h1);
      rdchk(IDX_WAKE_STS_B, 32'h2);
      check("wake_out", 32'h1, wake_event_out_n);
      seen_clr <= 1'b1;
      @(posedge core_clk);
      seen_clr <= 1'b0;
      @(posedge core_clk);
      check("host_seen", 32'h0, wake_seen);
      bus(1'b1, IDX_WAKE_EN_C, 32'h8);
      grouped_smi_in <= 1'b1;
      @(posedge core_clk);
      grouped_smi_in <= 1'b0;
      repeat (3) @(posedge core_clk);
      check("wake_out", 32'h0, wake_event_out_n);
      bus(1'b1, IDX_CONTROL, 32'h0);
      repeat (2) @(posedge core_clk);
      check("wake_out", 32'h1, wake_event_out_n);
   endtask

   task automatic t_irq();
      bus(1'b1, IDX_IRQ_CLEAR, 32'h3f);
      rdchk(IDX_IRQ_STATUS, 32'h0);
      bus(1'b1, IDX_IRQ_ENABLE, 32'h1);
      bus(1'b1, IDX_CONTROL, 32'h1);
      repeat (3) @(posedge core_clk);
      check("irq", 32'h1, irq);
      bus(1'b1, IDX_IRQ_ENABLE, 32'h0);
      repeat (2) @(posedge core_clk);
      check("irq", 32'h0, irq);
      rdchk(IDX_IRQ_STATUS, 32'h1);
      bus(1'b1, IDX_IRQ_CLEAR, 32'h1);
      bus(1'b1, IDX_IRQ_ENABLE, 32'h1);
      repeat (2) @(posedge core_clk);
      check("irq", 32'h0, irq);
      bus(1'b1, IDX_IRQ_ENABLE, 32'h4);
      src <= 4'h1;
      repeat (4) @(posedge core_clk);
      check("irq", 32'h1, irq);
      rdchk(IDX_IRQ_STATUS, 32'h4);
      src <= 4'h0;
   endtask

   initial
   begin
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      t_reset_values();
      t_enables_rw();
      t_smi_status();
      t_wake();
      t_irq();
      summarize();
   end
endmodule // test_wake_smi_regs

// ===== wake_smi_pkg.sv
package wake_smi_pkg;

   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_WAKE_STS_B  = 6'h05;
   localparam logic [5:0] IDX_WAKE_STS_C  = 6'h06;
   localparam logic [5:0] IDX_WAKE_STS_D  = 6'h07;
   localparam logic [5:0] IDX_WAKE_STS_E  = 6'h08;
   localparam logic [5:0] IDX_WAKE_EN_B   = 6'h0b;
   localparam logic [5:0] IDX_WAKE_EN_C   = 6'h0c;
   localparam logic [5:0] IDX_WAKE_EN_D   = 6'h0d;
   localparam logic [5:0] IDX_WAKE_EN_E   = 6'h0e;
   localparam logic [5:0] IDX_RSVD_ZERO   = 6'h0f;
   localparam logic [5:0] IDX_SMI_STS     = 6'h10;
   localparam logic [5:0] IDX_CONTROL     = 6'h20;
   localparam logic [5:0] IDX_IRQ_STATUS  = 6'h21;
   localparam logic [5:0] IDX_IRQ_ENABLE  = 6'h22;
   localparam logic [5:0] IDX_IRQ_CLEAR   = 6'h23;

   // Control register fields
   localparam int CTL_GLOBAL_WAKE_BIT     = 0;
   localparam int CTL_PP_ACTIVATE_BIT     = 1;

   // Grouped SMI wake source position in group c
   localparam int GROUPED_SMI_BIT         = 3;

   // SMI status field positions
   localparam int SMI_PARALLEL_BIT        = 1;
   localparam int SMI_SERIAL_TWO_BIT      = 2;
   localparam int SMI_SERIAL_ONE_BIT      = 3;
   localparam int SMI_FLOPPY_BIT          = 4;
   localparam int SMI_MIDI_BIT            = 5;

   // Interrupt status layout
   localparam int IRQ_WAKE_BIT            = 0;
   localparam int IRQ_WIDTH               = 6;

   // Reset values
   localparam logic [7:0] WAKE_EN_RESET   = 8'h00;
   localparam logic [7:0] WAKE_STS_RESET  = 8'h00;
   localparam logic [7:0] SMI_STS_RESET   = 8'h02;
   localparam logic [7:0] CONTROL_RESET   = 8'h00;
   localparam logic [5:0] IRQ_RESET       = 6'h00;

endpackage

// ===== wake_smi_props.sv
`timescale 1ns/100ps
module wake_smi_props
   import wake_smi_pkg::*;
(
   // Clock and resets
   input wire logic        core_clk,
   input wire logic        rst_n,
   input wire logic        main_power_reset,
   input wire logic        soft_reset,
   input wire logic        hard_reset,
   // Bus
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   // Sources and outputs
   input wire logic        serial_two_irq,
   input wire logic        serial_one_irq,
   input wire logic        floppy_irq,
   input wire logic        midi_unit_irq,
   input wire logic        wake_event_out_n,
   input wire logic        irq
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   wire logic [3:0] src = {midi_unit_irq, floppy_irq, serial_one_irq, serial_two_irq};
   wire logic       rd = hsel && htrans[1] && hready && !hwrite;
   wire logic [5:0] idx = haddr[7:2];
   wire logic       any_rst = main_power_reset || soft_reset || hard_reset;
   sequence rd_at(logic [5:0] i);
      rd && idx == i;
   endsequence
   // Reset pulse, then a status read that sees its effect
   sequence rst_then_rd;
      any_rst ##2 rd_at(IDX_SMI_STS);
   endsequence
   chk_resp_okay:
      assert property (hresp == 1'b0 && hreadyout) else $error("bus response not okay");
   chk_rsvd_zero:
      assert property (rd_at(IDX_RSVD_ZERO) |=> hrdata == 32'h0) else $error("reserved nonzero");
   chk_enable_width:
      assert property (rd && idx >= IDX_WAKE_EN_B && idx <= IDX_WAKE_EN_E |=> hrdata[31:8] == 0)
      else $error("enable upper bits set");
   chk_smi_reserved:
      assert property (rd_at(IDX_SMI_STS) |=> !hrdata[0] && hrdata[31:6] == 0)
      else $error("status reserved bits set");
   chk_smi_follow:
      assert property (rd_at(IDX_SMI_STS) ##0 src == $past(src) |=> hrdata[5:2] == $past(src, 2))
      else $error("status not following sources");
   chk_par_reset:
      assert property (rst_then_rd |=> hrdata[1]) else $error("parallel flag not set by reset");
   chk_reset_idle:
      assert property ($rose(rst_n) |-> wake_event_out_n && !irq) else $error("outputs active");
   chk_hrdata_hold:
      assert property (!rd |=> $stable(hrdata)) else $error("read data moved");
endmodule // wake_smi_props

bind wake_smi_regs wake_smi_props wake_smi_props_i (.*);

// ===== wake_smi_regs.sv
`timescale 1ns/100ps
// Functional notes
// - Wake output low when source enable, status and global enable are all one.
// - Disabled source still records status but never drives wake output.
// - Wake enables clear only on standby power-on reset, survive other resets.
// - Group b enable register holds pins 10..17 in bits 0..7, read-write.
// - Group c holds pins 20,21,22,24..27; bit 3 enables grouped SMI wake.
// - Group d maps pins 30,31,32,33,41,43,60,61 to bits 0..7.
// - Group e maps pins 50..57 to bits 0..7, read-write.
// - Offset 0f is reserved and always reads zero.
// - SMI status resets to 02; bit 1 set by every reset kind.
// - SMI status follows sources; writes never clear it.
// - Parallel flag reads one until port activated, then follows acknowledge input.
// - SMI bits 2..5 report serial two, serial one, floppy, MIDI; bits 0, 6, 7 reserved.
// - Wake status sets on source event regardless of any enable.
// - Writing one clears a wake status bit; zero leaves it.
module wake_smi_regs
   import wake_smi_pkg::*;
(
   // Clock and standby power-on reset
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   // Other reset kinds, one-cycle pulses from local logic
   input  wire logic        main_power_reset,
   input  wire logic        soft_reset,
   input  wire logic        hard_reset,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // Wake source pins, asynchronous
   input  wire logic [7:0]  wake_pins_b,
   input  wire logic [7:0]  wake_pins_c,
   input  wire logic [7:0]  wake_pins_d,
   input  wire logic [7:0]  wake_pins_e,
   input  wire logic        printer_acknowledge_in,
   // Device interrupt levels, local logic
   input  wire logic        grouped_smi_in,
   input  wire logic        serial_two_irq,
   input  wire logic        serial_one_irq,
   input  wire logic        floppy_irq,
   input  wire logic        midi_unit_irq,
   // Outputs
   output logic             wake_event_out_n,
   output logic             irq
);

   logic [31:0]          pins_meta_q;
   logic [31:0]          pins_sync_q;
   logic                 ack_meta_q;
   logic                 ack_sync_q;
   logic [31:0]          wake_src;
   logic [7:0]           wake_en_q [4];
   logic [7:0]           wake_sts_q [4];
   logic [7:0]           smi_sts_q;
   logic [7:0]           smi_prev_q;
   logic [7:0]           control_q;
   logic [IRQ_WIDTH-1:0] irq_sts_q;
   logic [IRQ_WIDTH-1:0] irq_en_q;
   logic [IRQ_WIDTH-1:0] irq_events;
   logic                 wake_active;
   logic                 wake_active_q;
   logic                 any_reset;
   logic                 wr_pend_q;
   logic [5:0]           wr_idx_q;
   logic                 addr_take;
   logic [5:0]           addr_idx;
   logic                 wr_now;
   logic [31:0]          rd_d;
   logic [31:0]          hrdata_q;

   assign any_reset = main_power_reset | soft_reset | hard_reset;
   assign addr_take = hsel & htrans[1] & hready;
   assign addr_idx  = haddr[7:2];
   assign wr_now    = wr_pend_q;

   // Zero wait state, always OKAY
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_q;

   // Pins pass two flops before use
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pins_meta_q <= 32'h0000_0000;
         pins_sync_q <= 32'h0000_0000;
      end
      else
      begin
         pins_meta_q <= {wake_pins_e, wake_pins_d, wake_pins_c, wake_pins_b};
         pins_sync_q <= pins_meta_q;
      end
   end

   // Acknowledge idles high; reset to it so no false low follows reset
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ack_meta_q <= 1'b1;
         ack_sync_q <= 1'b1;
      end
      else
      begin
         ack_meta_q <= printer_acknowledge_in;
         ack_sync_q <= ack_meta_q;
      end
   end

   always_comb
   begin
      wake_src = pins_sync_q;
      wake_src[8 + GROUPED_SMI_BIT] = grouped_smi_in;
   end

   // Write data arrives one cycle after the address phase
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_pend_q <= 1'b0;
         wr_idx_q  <= 6'h00;
      end
      else
      begin
         wr_pend_q <= addr_take & hwrite;
         wr_idx_q  <= addr_idx;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int g = 0; g < 4; g++)
         begin
            wake_en_q[g] <= WAKE_EN_RESET;
         end
      end
      else
      begin
         for (int g = 0; g < 4; g++)
         begin
            if (wr_now && wr_idx_q == IDX_WAKE_EN_B + 6'(g))
            begin
               wake_en_q[g] <= hwdata[7:0];
            end
         end
      end
   end

   // write one to clear, set wins
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int g = 0; g < 4; g++)
         begin
            wake_sts_q[g] <= WAKE_STS_RESET;
         end
      end
      else
      begin
         for (int g = 0; g < 4; g++)
         begin
            if (wr_now && wr_idx_q == IDX_WAKE_STS_B + 6'(g))
            begin
               wake_sts_q[g] <= (wake_sts_q[g] & ~hwdata[7:0]) | wake_src[g*8 +: 8];
            end
            else
            begin
               wake_sts_q[g] <= wake_sts_q[g] | wake_src[g*8 +: 8];
            end
         end
      end
   end

   // Control: global wake enable and parallel port activate
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         control_q <= CONTROL_RESET;
      end
      else if (any_reset)
      begin
         control_q <= CONTROL_RESET;
      end
      else if (wr_now && wr_idx_q == IDX_CONTROL)
      begin
         control_q <= {6'h00, hwdata[1:0]};
      end
   end

   always_comb
   begin
      wake_active = 1'b0;
      for (int g = 0; g < 4; g++)
      begin
         wake_active = wake_active | (|(wake_en_q[g] & wake_sts_q[g]));
      end
      wake_active = wake_active & control_q[CTL_GLOBAL_WAKE_BIT];
   end

   // Previous gated term, for the interrupt edge
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wake_active_q <= 1'b0;
      end
      else
      begin
         wake_active_q <= wake_active;
      end
   end

   // Registered so the pin never glitches
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wake_event_out_n <= 1'b1;
      end
      else
      begin
         wake_event_out_n <= ~wake_active;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         smi_sts_q <= SMI_STS_RESET;
      end
      else
      begin
         smi_sts_q <= 8'h00;
         if (any_reset || !control_q[CTL_PP_ACTIVATE_BIT])
         begin
            smi_sts_q[SMI_PARALLEL_BIT] <= 1'b1;
         end
         else
         begin
            smi_sts_q[SMI_PARALLEL_BIT] <= ack_sync_q;
         end
         smi_sts_q[SMI_SERIAL_TWO_BIT] <= serial_two_irq;
         smi_sts_q[SMI_SERIAL_ONE_BIT] <= serial_one_irq;
         smi_sts_q[SMI_FLOPPY_BIT]     <= floppy_irq;
         smi_sts_q[SMI_MIDI_BIT]       <= midi_unit_irq;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         smi_prev_q <= SMI_STS_RESET;
      end
      else
      begin
         smi_prev_q <= smi_sts_q;
      end
   end

   // Rising edges: wake output and each device flag
   always_comb
   begin
      irq_events = {smi_sts_q[SMI_MIDI_BIT:SMI_PARALLEL_BIT]
                    & ~smi_prev_q[SMI_MIDI_BIT:SMI_PARALLEL_BIT],
                    wake_active & ~wake_active_q};
   end

   // Sticky status, event beats a clear in the same cycle
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         irq_sts_q <= IRQ_RESET;
      end
      else if (wr_now && wr_idx_q == IDX_IRQ_CLEAR)
      begin
         irq_sts_q <= (irq_sts_q & ~hwdata[IRQ_WIDTH-1:0]) | irq_events;
      end
      else
      begin
         irq_sts_q <= irq_sts_q | irq_events;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         irq_en_q <= IRQ_RESET;
      end
      else if (wr_now && wr_idx_q == IDX_IRQ_ENABLE)
      begin
         irq_en_q <= hwdata[IRQ_WIDTH-1:0];
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         irq <= 1'b0;
      end
      else
      begin
         irq <= |(irq_sts_q & irq_en_q);
      end
   end

   // Read mux; and unmapped return zero
   always_comb
   begin
      rd_d = 32'h0000_0000;
      unique case (addr_idx)
         IDX_WAKE_STS_B: rd_d[7:0] = wake_sts_q[0];
         IDX_WAKE_STS_C: rd_d[7:0] = wake_sts_q[1];
         IDX_WAKE_STS_D: rd_d[7:0] = wake_sts_q[2];
         IDX_WAKE_STS_E: rd_d[7:0] = wake_sts_q[3];
         IDX_WAKE_EN_B:  rd_d[7:0] = wake_en_q[0];
         IDX_WAKE_EN_C:  rd_d[7:0] = wake_en_q[1];
         IDX_WAKE_EN_D:  rd_d[7:0] = wake_en_q[2];
         IDX_WAKE_EN_E:  rd_d[7:0] = wake_en_q[3];
         IDX_RSVD_ZERO:  rd_d = 32'h0000_0000;
         IDX_SMI_STS:    rd_d[7:0] = smi_sts_q;
         IDX_CONTROL:    rd_d[7:0] = control_q;
         IDX_IRQ_STATUS: rd_d[IRQ_WIDTH-1:0] = irq_sts_q;
         IDX_IRQ_ENABLE: rd_d[IRQ_WIDTH-1:0] = irq_en_q;
         default:        rd_d = 32'h0000_0000;
      endcase
   end

   // Sampled at the address phase, stands through the data phase
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hrdata_q <= 32'h0000_0000;
      end
      else if (addr_take && !hwrite)
      begin
         hrdata_q <= rd_d;
      end
   end

endmodule // wake_smi_regs
